// [rmp_pkg.sv]
// constants for the region memory protection unit
package rmp_pkg;
  // register byte addresses on the private peripheral bus
  localparam logic [31:0] RMP_TYPE_ADDR = 32'hE000ED90;
  localparam logic [31:0] RMP_CTRL_ADDR = 32'hE000ED94;
  localparam logic [31:0] RMP_SEL_ADDR  = 32'hE000ED98;
  localparam logic [31:0] RMP_LAST_ADDR = 32'hE000EDB8;
  // reset and fixed read values
  localparam logic [31:0] RMP_TYPE_VAL  = 32'h00000800;
  localparam logic [31:0] RMP_RST_VAL   = 32'h00000000;
  localparam int          RMP_NREG      = 8;
  // bus size codes
  localparam logic [1:0]  RMP_SZ_BYTE   = 2'h0;
  localparam logic [1:0]  RMP_SZ_HALF   = 2'h1;
  localparam logic [1:0]  RMP_SZ_WORD   = 2'h2;
  // base address word fields
  localparam int          RMP_BASE_LSB  = 5;
  localparam int          RMP_VALID_BIT = 4;
  // attribute and size word fields
  localparam int          RMP_NOEX_BIT  = 28;
  localparam int          RMP_PERM_LSB  = 24;
  localparam int          RMP_TYPX_LSB  = 19;
  localparam int          RMP_S_BIT     = 18;
  localparam int          RMP_C_BIT     = 17;
  localparam int          RMP_B_BIT     = 16;
  localparam int          RMP_SUBD_LSB  = 8;
  localparam int          RMP_SIZE_LSB  = 1;
  localparam int          RMP_EN_BIT    = 0;
  localparam logic [31:0] RMP_ATTR_MASK = 32'h173FFF3F;
  // smallest size code that has subregions (256 bytes)
  localparam logic [4:0]  RMP_SUB_MIN   = 5'h07;
  // access permission codes
  localparam logic [2:0]  RMP_PM_NONE   = 3'h0;
  localparam logic [2:0]  RMP_PM_PRW    = 3'h1;
  localparam logic [2:0]  RMP_PM_URO    = 3'h2;
  localparam logic [2:0]  RMP_PM_FULL   = 3'h3;
  localparam logic [2:0]  RMP_PM_PRO    = 3'h5;
  // memory types
  typedef enum logic [1:0] {
    RMP_MT_SO     = 2'h0,
    RMP_MT_DEVICE = 2'h1,
    RMP_MT_NORMAL = 2'h2,
    RMP_MT_RSVD   = 2'h3
  } rmp_mtype_e;
endpackage : rmp_pkg

// [rmp_unit.sv]
// region memory protection unit: register file and access checker
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - eight regions numbered 0-7 plus a background region.
// - overlapping matches take the attributes of the highest numbered region.
// - background uses default map, privileged only; unprivileged misses fault.
// - one region table serves instruction fetches and data accesses.
// - a prohibited access raises a memory management fault.
// - attribute register takes byte, half or word; others aligned words only.
// - select, base, attribute plus three alias pairs program up to four regions.
// - base write with valid set takes the region number from the data.
// - select register at fixed address, base and attribute follow by words.
// - regions of 256 bytes or more split into eight disableable subregions.
// - disable bit zero is the lowest subregion; a set bit excludes it.
// - disabled subregion falls to other matching regions, else to the background region.
// - type, share, cache, permission and execute-never govern; missing permission faults.
// - memory type decoded from type extension, cacheable and bufferable bits.
// - shareable bit ignored for strongly ordered, device and reserved encodings.
// - type extension top bit set: normal memory with outer and inner policy.
// - cache and share codes are stored and reported, never change behaviour.
// - strongly ordered accesses are flagged for strict program order.
// - new settings apply from the next access; barriers are the software's part.
// - permission codes decode to none, priv rw, user ro, full, priv ro, ro.
// - cache policy codes: none, wb rw-alloc, wt no-alloc, wb no-alloc.
module rmp_unit
  import rmp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  // private peripheral bus register port
  input  wire logic        cfg_sel,
  input  wire logic        cfg_wr,
  input  wire logic [31:0] cfg_addr,
  input  wire logic [1:0]  cfg_size,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  output logic             cfg_err,
  // access check from the core
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic        acc_priv,
  input  wire logic        acc_write,
  input  wire logic        acc_instr,
  output logic             chk_done,
  output logic             chk_fault,
  output logic             chk_hit,
  output logic      [2:0]  chk_region,
  output logic      [1:0]  chk_mtype,
  output logic             chk_shareable,
  output logic      [3:0]  chk_cache,
  output logic             chk_strict
);
  import rmp_pkg::*;

  // is the address inside an enabled region and not in a disabled subregion
  function automatic logic reg_match(input logic [31:0] a, input logic [26:0] b,
                                     input logic [31:0] at);
    logic [4:0]  sz;
    logic [31:0] msk;
    logic [2:0]  sub;
    sz  = at[RMP_SIZE_LSB +: 5];
    msk = 32'hFFFFFFFF << (6'(sz) + 6'h01);
    sub = 3'((a >> (6'(sz) - 6'h02)) & 32'h00000007);
    reg_match = at[RMP_EN_BIT] && ((a & msk) == ({b, 5'h00} & msk));
    if (sz >= RMP_SUB_MIN && at[RMP_SUBD_LSB + 32'(sub)]) begin
      reg_match = 1'b0;
    end
  endfunction : reg_match

  // permission check from the three bit permission code
  function automatic logic pm_ok(input logic [2:0] pm, input logic pr, input logic wr);
    case (pm)
      RMP_PM_NONE: pm_ok = 1'b0;
      RMP_PM_PRW:  pm_ok = pr;
      RMP_PM_URO:  pm_ok = pr || !wr;
      RMP_PM_FULL: pm_ok = 1'b1;
      RMP_PM_PRO:  pm_ok = pr && !wr;
      3'h6, 3'h7:  pm_ok = !wr;
      default:     pm_ok = 1'b0; // reserved code treated as no access
    endcase
  endfunction : pm_ok

  // memory type from type extension, cacheable and bufferable
  function automatic rmp_mtype_e mtype(input logic [2:0] tx, input logic c, input logic b);
    if (tx[2]) begin
      mtype = RMP_MT_NORMAL;
    end else begin
      case ({tx[1:0], c, b})
        4'h0:    mtype = RMP_MT_SO;
        4'h1:    mtype = RMP_MT_DEVICE;
        4'h2, 4'h3, 4'h4, 4'h7: mtype = RMP_MT_NORMAL;
        4'h8:    mtype = RMP_MT_DEVICE;
        default: mtype = RMP_MT_RSVD;
      endcase
    end
  endfunction : mtype

  // default memory map type, used by the background region
  function automatic rmp_mtype_e dflt_type(input logic [31:0] a);
    case (a[31:29])
      3'h2, 3'h4, 3'h5: dflt_type = RMP_MT_DEVICE;
      3'h7:             dflt_type = RMP_MT_SO;
      default:          dflt_type = RMP_MT_NORMAL;
    endcase
  endfunction : dflt_type

  // region table, shared by fetch and data checks
  logic [26:0] base_r [RMP_NREG];
  logic [31:0] attr_r [RMP_NREG];
  logic [2:0]  sel_r;
  logic        en_r;
  logic [31:0] cfg_rdata_r;
  logic        cfg_ack_r;
  logic        cfg_err_r;

  // bus decode: word index from the select register
  logic [31:0] off;
  logic [3:0]  widx;
  logic        in_map;
  logic        is_attr;
  logic        is_base;
  logic        size_ok;
  logic [31:0] attr_nxt;
  assign off     = cfg_addr - RMP_SEL_ADDR;
  assign widx    = off[5:2];
  assign in_map  = cfg_addr >= RMP_TYPE_ADDR && cfg_addr <= (RMP_LAST_ADDR + 32'h00000003);
  assign is_attr = cfg_addr >= RMP_SEL_ADDR && widx != 4'h0 && !widx[0];
  assign is_base = cfg_addr >= RMP_SEL_ADDR && widx[0];

  // word registers need aligned words; attributes also take bytes and halves
  always_comb begin
    size_ok = (cfg_size == RMP_SZ_WORD) && (cfg_addr[1:0] == 2'h0);
    if (is_attr) begin
      size_ok = (cfg_size == RMP_SZ_BYTE) ||
                (cfg_size == RMP_SZ_HALF && !cfg_addr[0]) || size_ok;
    end
  end

  // merge the written byte lanes into the selected attribute word
  always_comb begin
    attr_nxt = attr_r[sel_r];
    for (int i = 0; i < 4; i++) begin
      if (cfg_size == RMP_SZ_WORD ||
          (cfg_size == RMP_SZ_HALF && cfg_addr[1] == i[1]) ||
          (cfg_size == RMP_SZ_BYTE && cfg_addr[1:0] == i[1:0])) begin
        attr_nxt[i*8 +: 8] = cfg_wdata[i*8 +: 8];
      end
    end
    attr_nxt = attr_nxt & RMP_ATTR_MASK; // fields are stored, never acted on beyond use
  end

  logic wr_ok;
  assign wr_ok = cfg_sel && cfg_wr && in_map && size_ok;

  // region select and global enable; a valid base write redirects the select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_r <= 3'h0;
      en_r  <= 1'b0;
    end else if (wr_ok) begin
      if (cfg_addr == RMP_CTRL_ADDR) begin
        en_r <= cfg_wdata[0];
      end
      if (cfg_addr == RMP_SEL_ADDR) begin
        sel_r <= cfg_wdata[2:0];
      end
      if (is_base && cfg_wdata[RMP_VALID_BIT]) begin
        sel_r <= cfg_wdata[2:0];
      end
    end
  end

  // region table writes through the main pair or any alias pair
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < RMP_NREG; i++) begin
        base_r[i] <= 27'h0000000;
        attr_r[i] <= RMP_RST_VAL;
      end
    end else if (wr_ok && is_base) begin
      if (cfg_wdata[RMP_VALID_BIT]) begin
        base_r[cfg_wdata[2:0]] <= cfg_wdata[31:RMP_BASE_LSB];
      end else begin
        base_r[sel_r] <= cfg_wdata[31:RMP_BASE_LSB];
      end
    end else if (wr_ok && is_attr) begin
      attr_r[sel_r] <= attr_nxt;
    end
  end

  // one cycle register answer; bad size or unmapped address answers with error
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ack_r   <= 1'b0;
      cfg_err_r   <= 1'b0;
      cfg_rdata_r <= RMP_RST_VAL;
    end else begin
      cfg_ack_r   <= cfg_sel;
      cfg_err_r   <= cfg_sel && !(in_map && size_ok);
      cfg_rdata_r <= RMP_RST_VAL;
      if (cfg_sel && !cfg_wr && in_map && size_ok) begin
        if (cfg_addr == RMP_TYPE_ADDR) begin
          cfg_rdata_r <= RMP_TYPE_VAL;
        end else if (cfg_addr == RMP_CTRL_ADDR) begin
          cfg_rdata_r <= {31'h00000000, en_r};
        end else if (cfg_addr == RMP_SEL_ADDR) begin
          cfg_rdata_r <= {29'h00000000, sel_r};
        end else if (is_base) begin
          cfg_rdata_r <= {base_r[sel_r], 2'h0, sel_r};
        end else begin
          cfg_rdata_r <= attr_r[sel_r];
        end
      end
    end
  end

  // search all regions; a later, higher numbered match overrides
  logic [7:0]  match_c;
  logic        hit_c;
  logic [2:0]  hreg_c;
  logic [31:0] hattr_c;
  always_comb begin
    hit_c   = 1'b0;
    hreg_c  = 3'h0;
    hattr_c = RMP_RST_VAL;
    for (int i = 0; i < RMP_NREG; i++) begin
      match_c[i] = reg_match(acc_addr, base_r[i], attr_r[i]);
      if (match_c[i]) begin
        hit_c   = 1'b1;
        hreg_c  = 3'(i);
        hattr_c = attr_r[i];
      end
    end
  end

  // outcome of the check for the access presented this cycle
  rmp_mtype_e mt_c;
  logic       fault_c;
  logic       share_c;
  logic [3:0] cache_c;
  always_comb begin
    mt_c    = dflt_type(acc_addr);
    fault_c = 1'b0;
    share_c = 1'b0;
    cache_c = 4'h0;
    if (en_r && hit_c) begin
      mt_c    = mtype(hattr_c[RMP_TYPX_LSB +: 3], hattr_c[RMP_C_BIT], hattr_c[RMP_B_BIT]);
      fault_c = !pm_ok(hattr_c[RMP_PERM_LSB +: 3], acc_priv, acc_write) ||
                (acc_instr && hattr_c[RMP_NOEX_BIT]);
      share_c = (mt_c == RMP_MT_NORMAL) && hattr_c[RMP_S_BIT];
      cache_c = hattr_c[RMP_TYPX_LSB + 2] ?
                {hattr_c[RMP_TYPX_LSB +: 2], hattr_c[RMP_C_BIT], hattr_c[RMP_B_BIT]} :
                {2'h0, hattr_c[RMP_C_BIT], hattr_c[RMP_B_BIT]};
    end else if (en_r) begin
      fault_c = !acc_priv;
    end
  end

  // registered check result; settings written before the access are in force
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chk_done      <= 1'b0;
      chk_fault     <= 1'b0;
      chk_hit       <= 1'b0;
      chk_region    <= 3'h0;
      chk_mtype     <= RMP_MT_SO;
      chk_shareable <= 1'b0;
      chk_cache     <= 4'h0;
      chk_strict    <= 1'b0;
    end else begin
      chk_done      <= acc_valid;
      chk_fault     <= acc_valid && fault_c;
      chk_hit       <= acc_valid && en_r && hit_c;
      chk_region    <= hreg_c;
      chk_mtype     <= mt_c;
      chk_shareable <= share_c;
      chk_cache     <= cache_c;
      chk_strict    <= mt_c == RMP_MT_SO;
    end
  end

  assign cfg_rdata = cfg_rdata_r;
  assign cfg_ack   = cfg_ack_r;
  assign cfg_err   = cfg_err_r;

  // checks on the design's own behaviour
  property p_unpriv_miss;
    @(posedge clk) disable iff (!nrst)
    acc_valid && en_r && !hit_c && !acc_priv |=> chk_fault && !chk_hit;
  endproperty
  a_unpriv_miss: assert property (p_unpriv_miss) else $error("unprivileged miss no fault");

  property p_top_wins;
    @(posedge clk) disable iff (!nrst)
    acc_valid && en_r && match_c[7] |=> chk_hit && chk_region == 3'h7;
  endproperty
  a_top_wins: assert property (p_top_wins) else $error("region 7 did not win");

  property p_noex_fault;
    @(posedge clk) disable iff (!nrst)
    acc_valid && en_r && hit_c && acc_instr && hattr_c[RMP_NOEX_BIT] |=> chk_fault;
  endproperty
  a_noex_fault: assert property (p_noex_fault) else $error("fetch from no-exec region allowed");

  property p_pm_none;
    @(posedge clk) disable iff (!nrst)
    acc_valid && en_r && hit_c && hattr_c[RMP_PERM_LSB +: 3] == RMP_PM_NONE |=> chk_fault;
  endproperty
  a_pm_none: assert property (p_pm_none) else $error("no access code allowed access");

  property p_word_only;
    @(posedge clk) disable iff (!nrst)
    cfg_sel && !is_attr && cfg_size != RMP_SZ_WORD |=> cfg_ack && cfg_err;
  endproperty
  a_word_only: assert property (p_word_only) else $error("narrow access not refused");

  property p_valid_sel;
    @(posedge clk) disable iff (!nrst)
    wr_ok && is_base && cfg_wdata[RMP_VALID_BIT] |=> sel_r == $past(cfg_wdata[2:0]);
  endproperty
  a_valid_sel: assert property (p_valid_sel) else $error("valid base did not select");

  property p_share_ign;
    @(posedge clk) disable iff (!nrst)
    chk_done && chk_mtype != RMP_MT_NORMAL |-> !chk_shareable;
  endproperty
  a_share_ign: assert property (p_share_ign) else $error("shareable on non-normal");

  property p_strict;
    @(posedge clk) disable iff (!nrst)
    chk_done |-> chk_strict == (chk_mtype == RMP_MT_SO);
  endproperty
  a_strict: assert property (p_strict) else $error("strict order flag wrong");

  property p_off_nofault;
    @(posedge clk) disable iff (!nrst)
    acc_valid && !en_r |=> chk_done && !chk_fault && !chk_hit;
  endproperty
  a_off_nofault: assert property (p_off_nofault) else $error("fault while unit off");

  property p_read_back;
    @(posedge clk) disable iff (!nrst)
    cfg_sel && !cfg_wr && is_base && in_map && size_ok |=>
      cfg_rdata[31:5] == $past(base_r[sel_r]);
  endproperty
  a_read_back: assert property (p_read_back) else $error("base read mismatch");

endmodule : rmp_unit
`default_nettype wire

// [rmp_core_model.sv]
// core-side model that presents loads, stores and fetches to the checker
`timescale 1ns/1ps
`default_nettype none
module rmp_core_model
  import rmp_pkg::*;
(
  input  wire logic        clk,
  output logic             acc_valid,
  output logic      [31:0] acc_addr,
  output logic             acc_priv,
  output logic             acc_write,
  output logic             acc_instr,
  input  wire logic        chk_done,
  input  wire logic        chk_fault,
  input  wire logic        chk_hit,
  input  wire logic [2:0]  chk_region,
  input  wire logic [1:0]  chk_mtype,
  input  wire logic        chk_shareable,
  input  wire logic [3:0]  chk_cache,
  input  wire logic        chk_strict
);
  initial begin
    acc_valid = 1'b0;
    acc_addr  = 32'h00000000;
    acc_priv  = 1'b0;
    acc_write = 1'b0;
    acc_instr = 1'b0;
  end

  // one access at a time, so program order holds and a completed register
  // write is always seen by the next access, as after a barrier
  // no access runs while a region is being rewritten, as with interrupts masked
  task automatic access(input logic [31:0] a, input logic p, input logic w,
                        input logic i, output logic [12:0] r);
    int n;
    n = 0;
    @(negedge clk);
    acc_valid = 1'b1;
    acc_addr  = a;
    acc_priv  = p;
    acc_write = w;
    acc_instr = i;
    @(negedge clk);
    acc_valid = 1'b0;
    acc_addr  = ~a; // released address must not look stable
    while (chk_done !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    // region number carries no meaning on a miss
    r = {chk_fault, chk_hit, chk_hit ? chk_region : 3'h0, chk_mtype, chk_shareable,
         chk_cache, chk_strict};
    if (chk_done !== 1'b1) r = 'x;
  endtask : access
endmodule : rmp_core_model
`default_nettype wire

// [rmp_tb.sv]
// self-checking testbench for the region memory protection unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rmp_pkg::*;
  localparam logic [1:0] W = RMP_SZ_WORD;
  logic clk, nrst, cfg_sel, cfg_wr, cfg_ack, cfg_err;
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic [1:0] cfg_size;
  logic acc_valid, acc_priv, acc_write, acc_instr;
  logic [31:0] acc_addr;
  logic chk_done, chk_fault, chk_hit, chk_shareable, chk_strict;
  logic [2:0] chk_region;
  logic [1:0] chk_mtype;
  logic [3:0] chk_cache;
  int miscompares, tests_run, cycles;
  // allowed {priv rd, priv wr, user rd, user wr} per permission code
  logic [3:0] perm [8] = '{4'h0, 4'hC, 4'hE, 4'hF, 4'h0, 4'h8, 4'hA, 4'hA};
  // {type ext, 0 s c b, 0 share mtype, cache} per memory type case
  logic [15:0] mt_tab [9] = '{16'h0400, 16'h0511, 16'h0662, 16'h2410, 16'h1531,
                              16'h1020, 16'h6569, 16'h722E, 16'h5327};

  rmp_unit i_rmp_unit (.clk(clk), .nrst(nrst), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_size(cfg_size), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_priv(acc_priv),
    .acc_write(acc_write), .acc_instr(acc_instr), .chk_done(chk_done),
    .chk_fault(chk_fault), .chk_hit(chk_hit), .chk_region(chk_region),
    .chk_mtype(chk_mtype), .chk_shareable(chk_shareable), .chk_cache(chk_cache),
    .chk_strict(chk_strict));
  rmp_core_model i_rmp_core_model (.clk(clk), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_priv(acc_priv), .acc_write(acc_write),
    .acc_instr(acc_instr), .chk_done(chk_done), .chk_fault(chk_fault),
    .chk_hit(chk_hit), .chk_region(chk_region), .chk_mtype(chk_mtype),
    .chk_shareable(chk_shareable), .chk_cache(chk_cache), .chk_strict(chk_strict));

  always #2.5 clk = ~clk;

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one register request, then its single-cycle answer
  task automatic bus(input logic w, input logic [31:0] a, input logic [1:0] sz,
                     input logic [31:0] d, input logic e, input logic [31:0] x);
    int n;
    n = 0;
    @(negedge clk);
    cfg_sel   = 1'b1;
    cfg_wr    = w;
    cfg_addr  = a;
    cfg_size  = sz;
    cfg_wdata = d;
    @(negedge clk);
    cfg_sel   = 1'b0;
    cfg_addr  = ~a;
    cfg_wdata = ~d;
    while (cfg_ack !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    check({30'h0, cfg_ack, cfg_err}, {30'h0, 1'b1, e});
    if (!w) check(cfg_rdata, x);
  endtask : bus

  function automatic logic [12:0] ex(input logic f, input logic h, input logic [2:0] rg,
                                     input logic [1:0] mt, input logic s,
                                     input logic [3:0] c);
    return {f, h, rg, mt, s, c, mt == RMP_MT_SO};
  endfunction : ex

  task automatic ac(input logic [31:0] a, input logic p, input logic w, input logic i,
                    input logic [12:0] x);
    logic [12:0] r;
    i_rmp_core_model.access(a, p, w, i, r);
    check({19'h0, r}, {19'h0, x});
  endtask : ac

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    cfg_sel = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 32'h0;
    cfg_size = 2'h0;
    cfg_wdata = 32'h0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    // reset values and the fixed register map
    bus(0, RMP_TYPE_ADDR, W, 0, 0, RMP_TYPE_VAL);
    bus(0, RMP_CTRL_ADDR, W, 0, 0, RMP_RST_VAL);
    for (int k = 0; k < 3; k++) bus(0, RMP_SEL_ADDR + 4 * k, W, 0, 0, RMP_RST_VAL);
    // refused: unmapped, byte to select, misaligned word; none takes effect
    bus(0, 32'hE000EDBC, W, 0, 1, 0);
    bus(1, RMP_SEL_ADDR, RMP_SZ_BYTE, 5, 1, 0);
    bus(1, RMP_SEL_ADDR + 1, W, 5, 1, 0);
    bus(0, RMP_SEL_ADDR, W, 0, 0, 0);
    ac(32'h0, 0, 1, 0, ex(0, 0, 0, RMP_MT_NORMAL, 0, 0));
    // region 0: 4 KB full access; region 1: 256 B privileged rw, lowest subregion off
    bus(1, RMP_SEL_ADDR + 4, W, 32'h20000000, 0, 0);
    bus(1, RMP_SEL_ADDR + 8, W, 32'h03020017, 0, 0);
    bus(1, RMP_SEL_ADDR + 4, W, 32'h20000011, 0, 0);
    bus(1, 32'hE000EDA8, RMP_SZ_HALF, 32'h0000010F, 0, 0);
    bus(1, 32'hE000EDAA, RMP_SZ_HALF, 32'h01000000, 0, 0);
    bus(0, RMP_SEL_ADDR, W, 0, 0, 1);
    bus(0, 32'hE000EDA4, W, 0, 0, 32'h20000001);
    bus(0, 32'hE000EDA0, W, 0, 0, 32'h0100010F);
    bus(1, RMP_CTRL_ADDR, W, 1, 0, 0);
    ac(32'h20000000, 0, 0, 0, ex(0, 1, 0, RMP_MT_NORMAL, 0, 2));
    ac(32'h2000001F, 0, 1, 0, ex(0, 1, 0, RMP_MT_NORMAL, 0, 2));
    ac(32'h20000020, 0, 0, 0, ex(1, 1, 1, RMP_MT_SO, 0, 0));
    ac(32'h200000FF, 1, 1, 0, ex(0, 1, 1, RMP_MT_SO, 0, 0));
    ac(32'h20000100, 0, 0, 1, ex(0, 1, 0, RMP_MT_NORMAL, 0, 2));
    ac(32'h20001000, 0, 0, 0, ex(1, 0, 0, RMP_MT_NORMAL, 0, 0));
    ac(32'h40000000, 1, 1, 0, ex(0, 0, 0, RMP_MT_DEVICE, 0, 0));
    ac(32'hE0000000, 1, 0, 0, ex(0, 0, 0, RMP_MT_SO, 0, 0));
    // every permission code on region 0, by byte writes to its top lane
    bus(1, RMP_SEL_ADDR, W, 0, 0, 0);
    for (int pc = 0; pc < 8; pc++) begin
      bus(1, 32'hE000EDA3, RMP_SZ_BYTE, pc << 24, 0, 0);
      for (int m = 0; m < 4; m++)
        ac(32'h20000100, m < 2, m[0], 0,
           ex(!perm[pc][3 - m], 1, 0, RMP_MT_NORMAL, 0, 2));
    end
    bus(1, 32'hE000EDA3, RMP_SZ_BYTE, 32'h13000000, 0, 0);
    ac(32'h20000100, 1, 0, 1, ex(1, 1, 0, RMP_MT_NORMAL, 0, 2));
    ac(32'h20000100, 0, 0, 0, ex(0, 1, 0, RMP_MT_NORMAL, 0, 2));
    // memory type, shareable and cache policy decoding
    foreach (mt_tab[k]) begin
      bus(1, 32'hE000EDA2, RMP_SZ_HALF, {8'h03, 2'h0, mt_tab[k][14:12],
          mt_tab[k][10:8], 16'h0}, 0, 0);
      ac(32'h20000100, 1, 0, 0, ex(0, 1, 0, mt_tab[k][5:4], mt_tab[k][6],
         mt_tab[k][3:0]));
    end
    // the three alias pairs each program a user read-only device region, 5 to 7
    for (int k = 1; k < 4; k++) begin
      bus(1, 32'hE000ED9C + 8 * k, W, 32'h60000010 + k * 32'h1000 + k + 4, 0, 0);
      bus(1, 32'hE000EDA0 + 8 * k, W, 32'h02010017, 0, 0);
      ac(32'h60000000 + k * 32'h1000, 0, 1, 0, ex(1, 1, k + 4, RMP_MT_DEVICE, 0, 1));
      ac(32'h60000000 + k * 32'h1000, 0, 0, 0, ex(0, 1, k + 4, RMP_MT_DEVICE, 0, 1));
    end
    // disabling region 1 hands its span back to region 0 on the next access
    bus(1, RMP_SEL_ADDR, W, 1, 0, 0);
    bus(1, 32'hE000EDA0, RMP_SZ_BYTE, 32'h0000000E, 0, 0);
    ac(32'h20000020, 0, 1, 0, ex(0, 1, 0, RMP_MT_NORMAL, 0, 7));
    end_sim();
  end
endmodule : tb
`default_nettype wire
